/* File: rcp_regs.v */
`timescale 1ns/100ps
`default_nettype none
`include "rcp_consts.vh"
module rcp_regs (
   input wire clk_sys_in,                      // PCI clock
   input wire rstn_in,                         // Sync reset, low
   input wire [`RCP_ADDR_W-1:0] io_addr_in,    // I/O byte address
   input wire [3:0] io_be_in,                  // Byte enables
   input wire io_wr_in,                        // Write strobe
   input wire io_rd_in,                        // Read strobe
   input wire [31:0] io_wdata_in,              // Write data
   output reg [31:0] io_rdata_out,             // Read data, next cycle
   input wire [2:0] acc_req_in,                // Channel update requests
   input wire [`RCP_VAL_W-1:0] acc_inc_in,     // Accumulator step
   output reg [2:0] acc_done_out,              // Update done pulses
   output reg [`RCP_VAL_W-1:0] acc_value_out,  // Updated accumulator
   output wire converter_off_out,              // Converter disabled
   output wire [2:0] accum_block_out,          // P1,P2,REC blocks
   input wire ac_bitclk_in,                    // Link bit clock
   input wire ac_sdi_in,                       // Link serial in
   output reg ac_sync_out,                     // Link frame sync
   output reg ac_sdo_out                       // Link serial out
);
   localparam [2:0] R_IDLE = 3'h0;
   localparam [2:0] R_HRD = 3'h1;
   localparam [2:0] R_HCAP = 3'h2;
   localparam [2:0] R_ARD = 3'h3;
   localparam [2:0] R_AWR = 3'h4;
   localparam [1:0] C_IDLE = 2'h0;
   localparam [1:0] C_WAIT = 2'h1;
   localparam [1:0] C_SEND = 2'h2;
   localparam [1:0] C_RESP = 2'h3;

   function [1:0] ch_code;
      input [2:0] req;
      begin
         if (req[0]) begin
            ch_code = 2'h0;
         end else if (req[1]) begin
            ch_code = 2'h1;
         end else begin
            ch_code = 2'h2;
         end
      end
   endfunction

   // Serial bit for a frame position while a command is carried
   function tx_bit;
      input [7:0] pos;
      input rd;
      input [6:0] idx;
      input [15:0] dat;
      reg [19:0] s1;
      reg [19:0] s2;
      reg [7:0] o1;
      reg [7:0] o2;
      begin
         s1 = {rd, idx, 12'h000};
         s2 = {dat, 4'h0};
         o1 = pos - `RCP_S1_FIRST;
         o2 = pos - `RCP_S2_FIRST;
         if (pos == `RCP_TAG_FRAME || pos == `RCP_TAG_S1) begin
            tx_bit = 1'b1;
         end else if (pos == `RCP_TAG_S2) begin
            tx_bit = ~rd;
         end else if (pos >= `RCP_S1_FIRST && pos <= `RCP_S1_LAST) begin
            tx_bit = s1[5'd19 - o1[4:0]];
         end else if (pos >= `RCP_S2_FIRST && pos <= `RCP_S2_LAST) begin
            tx_bit = s2[5'd19 - o2[4:0]];
         end else begin
            tx_bit = 1'b0;
         end
      end
   endfunction

   wire wr_full = io_wr_in && (io_be_in == `RCP_BE_FULL);
   wire hit_conv = (io_addr_in == `RCP_OFS_CONV);
   wire hit_codec = (io_addr_in == `RCP_OFS_CODEC);

   // Converter register fields
   reg [6:0] loc_ff;
   reg wsel_ff;
   reg pend_ram_ff;
   reg off_ff;
   reg [2:0] blk_ff;
   reg [15:0] val_ff;
   reg [2:0] rst_ff;
   reg [1:0] ch_ff;
   reg [2:0] nxt_rst;
   reg [1:0] nxt_ch;
   wire [15:0] ram_rdata;
   reg ram_wr;
   reg [6:0] ram_loc;
   reg [15:0] ram_wdata;

   wire conv_wr = wr_full && hit_conv;
   wire [2:0] live_req = acc_req_in & ~blk_ff & {3{~off_ff}};

   assign converter_off_out = off_ff;
   assign accum_block_out = blk_ff;

   rcp_conv_ram u_ram (
      .clk_sys_in(clk_sys_in),
      .wr_in(ram_wr),
      .loc_in(ram_loc),
      .wdata_in(ram_wdata),
      .rdata_out(ram_rdata)
   );

   // RAM port arbitration; host access has priority over channels
   always @* begin
      nxt_rst = rst_ff;
      nxt_ch = ch_ff;
      ram_wr = 1'b0;
      ram_loc = loc_ff;
      ram_wdata = val_ff;
      case (rst_ff)
         R_IDLE: begin
            if (pend_ram_ff) begin
               ram_wr = wsel_ff;
               if (!wsel_ff) begin
                  nxt_rst = R_HRD;
               end
            end else if (live_req != 3'h0) begin
               nxt_ch = ch_code(live_req);
               ram_loc = `RCP_ACC_BASE + {5'h00, nxt_ch};
               nxt_rst = R_ARD;
            end
         end
         R_HRD: begin
            nxt_rst = R_IDLE;
         end
         R_ARD: begin
            ram_loc = `RCP_ACC_BASE + {5'h00, ch_ff};
            nxt_rst = R_AWR;
         end
         R_AWR: begin
            ram_loc = `RCP_ACC_BASE + {5'h00, ch_ff};
            ram_wdata = ram_rdata + acc_inc_in;
            ram_wr = 1'b1;
            nxt_rst = R_IDLE;
         end
         default: begin
            nxt_rst = R_IDLE;
         end
      endcase
   end

   always @(posedge clk_sys_in) begin
      if (!rstn_in) begin
         loc_ff <= 7'h00;
         wsel_ff <= 1'b0;
         pend_ram_ff <= 1'b0;
         off_ff <= 1'b0;
         blk_ff <= 3'h0;
         val_ff <= 16'h0000;
         rst_ff <= R_IDLE;
         ch_ff <= 2'h0;
         acc_done_out <= 3'h0;
         acc_value_out <= 16'h0000;
      end else begin
         rst_ff <= nxt_rst;
         ch_ff <= nxt_ch;
         acc_done_out <= 3'h0;
         if (rst_ff == R_AWR) begin
            acc_done_out[ch_ff] <= 1'b1;
            acc_value_out <= ram_wdata;
         end
         if (conv_wr) begin
            off_ff <= io_wdata_in[`RCP_OFF_BIT];
            blk_ff <= io_wdata_in[`RCP_BLK_HI:`RCP_BLK_LO];
         end
         // A second access while busy is dropped; software polls first
         if (conv_wr && !pend_ram_ff && rst_ff != R_HRD) begin
            loc_ff <= io_wdata_in[`RCP_LOC_HI:`RCP_LOC_LO];
            wsel_ff <= io_wdata_in[`RCP_WSEL_BIT];
            val_ff <= io_wdata_in[`RCP_VAL_HI:`RCP_VAL_LO];
            pend_ram_ff <= 1'b1;
         end else if (rst_ff == R_IDLE && pend_ram_ff && wsel_ff) begin
            pend_ram_ff <= 1'b0;
         end else if (rst_ff == R_HRD) begin
            val_ff <= ram_rdata;
            pend_ram_ff <= 1'b0;
         end
      end
   end

   // Link inputs from the codec domain, two flops each
   reg [1:0] bclk_sync_ff;
   reg [1:0] sdi_sync_ff;
   reg bclk_prev_ff;
   always @(posedge clk_sys_in) begin
      if (!rstn_in) begin
         bclk_sync_ff <= 2'h0;
         sdi_sync_ff <= 2'h0;
         bclk_prev_ff <= 1'b0;
      end else begin
         bclk_sync_ff <= {bclk_sync_ff[0], ac_bitclk_in};
         sdi_sync_ff <= {sdi_sync_ff[0], ac_sdi_in};
         bclk_prev_ff <= bclk_sync_ff[1];
      end
   end
   wire bclk_rise = bclk_sync_ff[1] && !bclk_prev_ff;
   wire bclk_fall = !bclk_sync_ff[1] && bclk_prev_ff;
   wire sdi_s = sdi_sync_ff[1];

   // Codec command and response state
   reg [1:0] cst_ff;
   reg [1:0] nxt_cst;
   reg [7:0] pos_ff;
   reg cmd_read_select_ff;
   reg [6:0] cmd_codec_reg_index_ff;
   reg [15:0] cmd_write_value_ff;
   reg codec_access_pending_ff;
   reg ready_ff;
   reg resp_read_select_ff;
   reg [6:0] resp_codec_reg_index_ff;
   reg [15:0] resp_read_value_ff;
   reg [2:0] frames_ff;
   reg tag1_ff;
   reg [19:0] s1_ff;
   reg [19:0] s2_ff;

   wire codec_wr = wr_full && hit_codec;
   wire frame_end = bclk_fall && (pos_ff == `RCP_FRAME_LAST);
   wire resp_ok = tag1_ff &&
      (s1_ff[`RCP_RSP_IDX_HI:`RCP_RSP_IDX_LO] == cmd_codec_reg_index_ff);

   always @* begin
      nxt_cst = cst_ff;
      case (cst_ff)
         C_IDLE: begin
            if (codec_wr && !codec_access_pending_ff) begin
               nxt_cst = C_WAIT;
            end
         end
         C_WAIT: begin
            if (frame_end) begin
               nxt_cst = C_SEND;
            end
         end
         C_SEND: begin
            if (frame_end) begin
               nxt_cst = cmd_read_select_ff ? C_RESP : C_IDLE;
            end
         end
         C_RESP: begin
            if (frame_end && (resp_ok || frames_ff == 3'h0)) begin
               nxt_cst = C_IDLE;
            end
         end
         default: begin
            nxt_cst = C_IDLE;
         end
      endcase
   end

   always @(posedge clk_sys_in) begin
      if (!rstn_in) begin
         cst_ff <= C_IDLE;
         pos_ff <= `RCP_FRAME_LAST;
         cmd_read_select_ff <= 1'b0;
         cmd_codec_reg_index_ff <= 7'h00;
         cmd_write_value_ff <= 16'h0000;
         codec_access_pending_ff <= 1'b0;
         ready_ff <= 1'b0;
         resp_read_select_ff <= 1'b0;
         resp_codec_reg_index_ff <= 7'h00;
         resp_read_value_ff <= 16'h0000;
         frames_ff <= 3'h0;
         tag1_ff <= 1'b0;
         s1_ff <= 20'h00000;
         s2_ff <= 20'h00000;
         ac_sync_out <= 1'b0;
         ac_sdo_out <= 1'b0;
      end else begin
         cst_ff <= nxt_cst;
         if (bclk_rise) begin
            pos_ff <= pos_ff + 8'h01;
            ac_sync_out <= ((pos_ff + 8'h01) < `RCP_SYNC_END);
            ac_sdo_out <= (cst_ff == C_SEND) &&
               tx_bit(pos_ff + 8'h01, cmd_read_select_ff,
                  cmd_codec_reg_index_ff, cmd_write_value_ff);
         end
         if (bclk_fall) begin
            if (pos_ff == `RCP_TAG_S1) begin
               tag1_ff <= sdi_s;
            end
            if (pos_ff >= `RCP_S1_FIRST && pos_ff <= `RCP_S1_LAST) begin
               s1_ff <= {s1_ff[18:0], sdi_s};
            end
            if (pos_ff >= `RCP_S2_FIRST && pos_ff <= `RCP_S2_LAST) begin
               s2_ff <= {s2_ff[18:0], sdi_s};
            end
         end
         if (cst_ff == C_IDLE && nxt_cst == C_WAIT) begin
            cmd_read_select_ff <= io_wdata_in[`RCP_CRD_BIT];
            cmd_codec_reg_index_ff <=
               io_wdata_in[`RCP_IDX_HI:`RCP_IDX_LO];
            cmd_write_value_ff <=
               io_wdata_in[`RCP_VAL_HI:`RCP_VAL_LO];
            codec_access_pending_ff <= 1'b1;
            ready_ff <= 1'b0;
            resp_read_select_ff <= io_wdata_in[`RCP_CRD_BIT];
            resp_codec_reg_index_ff <=
               io_wdata_in[`RCP_IDX_HI:`RCP_IDX_LO];
         end
         if (cst_ff == C_SEND && frame_end) begin
            frames_ff <= `RCP_RESP_FRAMES;
            if (!cmd_read_select_ff) begin
               codec_access_pending_ff <= 1'b0;
            end
         end
         if (cst_ff == C_RESP && frame_end) begin
            frames_ff <= frames_ff - 3'h1;
            if (resp_ok) begin
               resp_read_value_ff <=
                  s2_ff[`RCP_RSP_DAT_HI:`RCP_RSP_DAT_LO];
               ready_ff <= 1'b1;
               codec_access_pending_ff <= 1'b0;
            end else if (frames_ff == 3'h0) begin
               // Silent codec: give up, ready stays low
               codec_access_pending_ff <= 1'b0;
            end
         end
      end
   end

   // Read data, registered; longword reads only are meaningful
   always @(posedge clk_sys_in) begin
      if (!rstn_in) begin
         io_rdata_out <= `RCP_RESET_WORD;
      end else if (io_rd_in) begin
         io_rdata_out <= `RCP_RESET_WORD;
         if (hit_conv) begin
            io_rdata_out[`RCP_LOC_HI:`RCP_LOC_LO] <= loc_ff;
            io_rdata_out[`RCP_WSEL_BIT] <= wsel_ff;
            io_rdata_out[`RCP_BUSY_BIT] <= pend_ram_ff;
            io_rdata_out[`RCP_OFF_BIT] <= off_ff;
            io_rdata_out[`RCP_BLK_HI:`RCP_BLK_LO] <= blk_ff;
            io_rdata_out[`RCP_VAL_HI:`RCP_VAL_LO] <= val_ff;
         end else if (hit_codec) begin
            io_rdata_out[`RCP_RDY_BIT] <= ready_ff;
            io_rdata_out[`RCP_PEND_BIT] <=
               codec_access_pending_ff;
            io_rdata_out[`RCP_CRD_BIT] <= resp_read_select_ff;
            io_rdata_out[`RCP_IDX_HI:`RCP_IDX_LO] <=
               resp_codec_reg_index_ff;
            io_rdata_out[`RCP_VAL_HI:`RCP_VAL_LO] <=
               resp_read_value_ff;
         end
      end
   end
endmodule
`default_nettype wire

/* File: rcp_consts.vh */
`ifndef RCP_CONSTS_VH
`define RCP_CONSTS_VH
`define RCP_ADDR_W 6
`define RCP_OFS_CONV 6'h10
`define RCP_OFS_CODEC 6'h14
`define RCP_BE_FULL 4'hF
`define RCP_LOC_HI 31
`define RCP_LOC_LO 25
`define RCP_WSEL_BIT 24
`define RCP_BUSY_BIT 23
`define RCP_OFF_BIT 22
`define RCP_BLK_HI 21
`define RCP_BLK_LO 19
`define RCP_VAL_HI 15
`define RCP_VAL_LO 0
`define RCP_RDY_BIT 31
`define RCP_PEND_BIT 30
`define RCP_CRD_BIT 23
`define RCP_IDX_HI 22
`define RCP_IDX_LO 16
`define RCP_RESET_WORD 32'h00000000
`define RCP_LOC_W 7
`define RCP_VAL_W 16
`define RCP_RAM_DEPTH 128
`define RCP_ACC_BASE 7'h70
`define RCP_FRAME_LAST 8'hFF
`define RCP_SYNC_END 8'h10
`define RCP_S1_FIRST 8'h10
`define RCP_S1_LAST 8'h23
`define RCP_S2_FIRST 8'h24
`define RCP_S2_LAST 8'h37
`define RCP_TAG_FRAME 8'h00
`define RCP_TAG_S1 8'h01
`define RCP_TAG_S2 8'h02
`define RCP_SLOT_W 20
`define RCP_RESP_FRAMES 3'h4
`define RCP_RSP_IDX_HI 18
`define RCP_RSP_IDX_LO 12
`define RCP_RSP_DAT_HI 19
`define RCP_RSP_DAT_LO 4
`endif

/* File: rcp_conv_ram.v */
`timescale 1ns/100ps
`default_nettype none
`include "rcp_consts.vh"
module rcp_conv_ram (
   input wire clk_sys_in,                      // System clock
   input wire wr_in,                           // Write strobe
   input wire [`RCP_LOC_W-1:0] loc_in,         // Location index
   input wire [`RCP_VAL_W-1:0] wdata_in,       // Write value
   output reg [`RCP_VAL_W-1:0] rdata_out       // Registered read value
);
   reg [`RCP_VAL_W-1:0] mem_ff [0:`RCP_RAM_DEPTH-1];

   // No reset on storage; contents are software-initialised
   always @(posedge clk_sys_in) begin
      if (wr_in) begin
         mem_ff[loc_in] <= wdata_in;
      end
      rdata_out <= mem_ff[loc_in];
   end
endmodule
`default_nettype wire

/* File: rcp_regs_sva.sv */
`timescale 1ns/100ps
`default_nettype none
`include "rcp_consts.vh"
module rcp_regs_sva (
   input wire logic clk_sys_in,           // Clock
   input wire logic rstn_in,              // Reset, low
   input wire logic [5:0] io_addr_in,     // Address
   input wire logic [3:0] io_be_in,       // Byte enables
   input wire logic io_wr_in,             // Write strobe
   input wire logic io_rd_in,             // Read strobe
   input wire logic [31:0] io_wdata_in,   // Write data
   input wire logic [31:0] io_rdata_out,  // Read data
   input wire logic [2:0] acc_req_in,     // Update requests
   input wire logic [2:0] acc_done_out,   // Done pulses
   input wire logic converter_off_out,    // Converter off
   input wire logic [2:0] accum_block_out // Update blocks
);
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (!rstn_in);
   sequence s_cwr;
      io_wr_in && io_addr_in == `RCP_OFS_CONV && io_be_in == 4'hF;
   endsequence
   sequence s_rd(a);
      io_rd_in && io_addr_in == a;
   endsequence
   a_off_follow: assert property (
      s_cwr |=> converter_off_out == $past(io_wdata_in[22]))
      else $error("converter off bit not taken");
   a_block_follow: assert property (
      s_cwr |=> accum_block_out == $past(io_wdata_in[21:19]))
      else $error("update block bits not taken");
   a_done_single: assert property (
      acc_done_out != 3'h0 |=> acc_done_out == 3'h0)
      else $error("done pulse longer than one cycle");
   // Request is taken exactly three edges before done is sampled
   a_block_gate: assert property (
      (acc_done_out & $past(accum_block_out, 3)) == 3'h0)
      else $error("blocked channel updated");
   a_off_gate: assert property (
      acc_done_out != 3'h0 |-> !$past(converter_off_out, 3))
      else $error("update while converter off");
   a_req_cause: assert property (
      (acc_done_out & ~$past(acc_req_in, 3)) == 3'h0)
      else $error("update without request");
   a_codec_zero: assert property (
      s_rd(`RCP_OFS_CODEC) |=> io_rdata_out[29:24] == 6'h00)
      else $error("codec word bits 29:24 not zero");
   a_unmapped_zero: assert property (
      io_rd_in && io_addr_in != `RCP_OFS_CONV
      && io_addr_in != `RCP_OFS_CODEC |=> io_rdata_out == 32'h00000000)
      else $error("unmapped read not zero");
   a_rdata_hold: assert property (
      !io_rd_in |=> $stable(io_rdata_out))
      else $error("read data changed without read");
endmodule
bind rcp_regs rcp_regs_sva u_sva (.clk_sys_in, .rstn_in, .io_addr_in,
   .io_be_in, .io_wr_in, .io_rd_in, .io_wdata_in, .io_rdata_out,
   .acc_req_in, .acc_done_out, .converter_off_out, .accum_block_out);
`default_nettype wire

/* File: rcp_codec_model.sv */
`timescale 1ns/100ps
`default_nettype none
module rcp_codec_model (
   input wire logic mute_in,  // Withhold read replies
   input wire logic sync_in,  // Frame sync
   input wire logic sdo_in,   // Serial from controller
   output logic bitclk_out,   // Free running bit clock
   output logic sdi_out       // Serial to controller
);
   logic [15:0] mem [0:127];
   logic [55:0] cmd;
   logic [7:0] pos, q;
   logic prev, pend, ans;
   logic [6:0] ridx;
   initial begin
      bitclk_out = 1'b0;
      sdi_out = 1'b0;
      pos = 8'h00;
      prev = 1'b0;
      pend = 1'b0;
      ans = 1'b0;
      ridx = 7'h00;
      cmd = 56'h0;
      for (int i = 0; i < 128; i++) mem[i] = 16'h0000;
      forever #400 bitclk_out = ~bitclk_out;
   end
   always @(negedge bitclk_out) begin
      if (sync_in && !prev) pos = 8'h00;
      else pos = pos + 8'h01;
      prev = sync_in;
      if (pos < 8'h38) cmd[55 - pos] = sdo_in;
      if (pos == 8'h37 && cmd[54]) begin
         if (cmd[39]) begin
            pend = !mute_in;
            ridx = cmd[38:32];
         end else mem[cmd[38:32]] = cmd[19:4];
      end
      // Reply only in the frame after the command
      if (pos == 8'hFF) begin
         ans = pend;
         pend = 1'b0;
      end
   end
   always @(posedge bitclk_out) begin
      q = pos + 8'h01;
      sdi_out <= ans && (q == 8'h01 || (q >= 8'h11 && q <= 8'h17 &&
         ridx[23 - q]) || (q >= 8'h24 && q <= 8'h33 &&
         mem[ridx][51 - q]));
   end
endmodule
`default_nettype wire

/* File: rcp_regs_bench.sv */
`timescale 1ns/100ps
`default_nettype none
`include "rcp_consts.vh"
module rcp_regs_bench;
   logic clk_sys_in, rstn_in, io_wr_in, io_rd_in, mute;
   logic [5:0] io_addr_in;
   logic [3:0] io_be_in;
   logic [31:0] io_wdata_in, got;
   logic [2:0] acc_req_in;
   logic [15:0] acc_inc_in;
   wire [31:0] io_rdata_out;
   wire [2:0] acc_done_out, accum_block_out;
   wire [15:0] acc_value_out;
   wire converter_off_out, bclk, sdi, sync, sdo;
   integer n_mismatch, checked, cyc, i, seen;
   rcp_regs uut (.clk_sys_in, .rstn_in, .io_addr_in, .io_be_in,
      .io_wr_in, .io_rd_in, .io_wdata_in, .io_rdata_out, .acc_req_in,
      .acc_inc_in, .acc_done_out, .acc_value_out, .converter_off_out,
      .accum_block_out, .ac_bitclk_in(bclk), .ac_sdi_in(sdi),
      .ac_sync_out(sync), .ac_sdo_out(sdo));
   rcp_codec_model u_codec (.mute_in(mute), .sync_in(sync),
      .sdo_in(sdo), .bitclk_out(bclk), .sdi_out(sdi));
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task tick(input integer n);
      repeat (n) @(posedge clk_sys_in);
   endtask
   // Callers stand at a clock edge
   task wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] be);
      io_addr_in <= a;
      io_wdata_in <= d;
      io_be_in <= be;
      io_wr_in <= 1'b1;
      tick(1);
      io_wr_in <= 1'b0;
   endtask
   task rdw(input logic [5:0] a);
      io_addr_in <= a;
      io_rd_in <= 1'b1;
      tick(1);
      io_rd_in <= 1'b0;
      tick(1);
      got = io_rdata_out;
   endtask
   task poll;
      for (int j = 0; j < 200; j++) begin
         rdw(`RCP_OFS_CODEC);
         if (got[30] === 1'b0) break;
         tick(100);
      end
      chk("codec pending", 32'h0, {31'h0, got[30]});
   endtask
   task t_regs;
      rdw(`RCP_OFS_CONV);
      chk("conv reset", 32'h0, got);
      rdw(`RCP_OFS_CODEC);
      chk("codec reset", 32'h0, got);
      rdw(6'h20);
      chk("unmapped", 32'h0, got);
      wr(`RCP_OFS_CONV, 32'h00400000, 4'h3);
      tick(2);
      chk("partial write", 32'h0, {31'h0, converter_off_out});
      $display("t_regs done");
   endtask
   task t_ram;
      wr(`RCP_OFS_CONV, {7'd5, 1'b1, 8'h00, 16'hBEEF}, 4'hF);
      rdw(`RCP_OFS_CONV);
      chk("busy set", 32'h1, {31'h0, got[23]});
      tick(3);
      wr(`RCP_OFS_CONV, {7'd6, 1'b1, 8'h00, 16'h1111}, 4'hF);
      tick(4);
      wr(`RCP_OFS_CONV, {7'd5, 1'b0, 8'h00, 16'h0000}, 4'hF);
      tick(4);
      rdw(`RCP_OFS_CONV);
      chk("busy clear", 32'h0, {31'h0, got[23]});
      chk("ram value", 32'hBEEF, {16'h0, got[15:0]});
      chk("ram fields", 32'h0A, {24'h0, got[31:24]});
      $display("t_ram done");
   endtask
   task t_acc;
      for (i = 0; i < 3; i++) begin
         wr(`RCP_OFS_CONV, {7'h70 + i[6:0], 1'b1, 8'h00, 16'h0100}, 4'hF);
         tick(4);
         wr(`RCP_OFS_CONV, 32'h00080000 << i, 4'hF);
         tick(4);
         acc_req_in[i] <= 1'b1;
         acc_inc_in <= 16'h0011;
         seen = 0;
         repeat (10) begin
            tick(1);
            if (acc_done_out[i] !== 1'b0) seen++;
         end
         chk("blocked done", 32'h0, seen);
         wr(`RCP_OFS_CONV, 32'h00400000, 4'hF);
         repeat (10) begin
            tick(1);
            if (acc_done_out[i] !== 1'b0) seen++;
         end
         chk("off done", 32'h0, seen);
         wr(`RCP_OFS_CONV, 32'h0, 4'hF);
         // Held through the host read op; dropped on the edge done rises
         tick(5);
         acc_req_in[i] <= 1'b0;
         seen = 0;
         repeat (4) begin
            tick(1);
            if (acc_done_out[i] !== 1'b0) seen++;
         end
         chk("done pulses", 32'h1, seen);
         chk("accum value", 32'h0111, {16'h0, acc_value_out});
         tick(1);
      end
      $display("t_acc done");
   endtask
   task t_codec;
      wr(`RCP_OFS_CODEC, {8'h00, 1'b0, 7'h02, 16'h1234}, 4'hF);
      rdw(`RCP_OFS_CODEC);
      chk("pending set", 32'h1, {31'h0, got[30]});
      wr(`RCP_OFS_CODEC, {8'h00, 1'b0, 7'h03, 16'h5555}, 4'hF);
      poll();
      chk("codec write", 32'h1234, {16'h0, u_codec.mem[2]});
      chk("busy refusal", 32'h0, {16'h0, u_codec.mem[3]});
      wr(`RCP_OFS_CODEC, {8'h00, 1'b1, 7'h02, 16'h0000}, 4'hF);
      poll();
      chk("codec read", 32'h80821234, got);
      mute <= 1'b1;
      wr(`RCP_OFS_CODEC, {8'h00, 1'b1, 7'h02, 16'h0000}, 4'hF);
      poll();
      chk("no reply ready", 32'h0, {31'h0, got[31]});
      mute <= 1'b0;
      $display("t_codec done");
   endtask
   task wrap_up;
      $display("Checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      clk_sys_in = 1'b0;
      forever #50 clk_sys_in = ~clk_sys_in;
   end
   always @(posedge clk_sys_in) begin
      cyc++;
      if (cyc == 60000) begin
         n_mismatch++;
         wrap_up();
      end
   end
   initial begin
      {rstn_in, io_wr_in, io_rd_in, mute} = 4'h0;
      io_addr_in = 6'h00;
      io_be_in = 4'h0;
      io_wdata_in = 32'h0;
      acc_req_in = 3'h0;
      acc_inc_in = 16'h0;
      {n_mismatch, checked, cyc} = 0;
      tick(3);
      rstn_in <= 1'b1;
      t_regs();
      t_ram();
      t_acc();
      t_codec();
      wrap_up();
   end
endmodule
`default_nettype wire
